// [design/ssfp_packer.sv]
`timescale 1ns/1ns
// Summary of operation
// R1: The 8-byte standard frame only leaves the device toward the controller as its input data.
// R2: Each frame refreshes every 5 ms times the packet-interval multiple set by software.
// R3: Standard frame bytes 1 safe, 2 plain, 4 case, 5 restart, 7 faults; 3 and 6 reserved zero.
// R4: The 16-byte frame also goes device to controller, flagged as the safety-connection frame.
// R5: Safety frame bytes 0 status, 1 safe, 4 plain, 7 restart, 10 case, 15 faults.
// R6: In each per-path byte bit n-1 is path n; paths 5 to 8 exist only on the extended variant.
// R7: Status byte bit 5 tamper, 4 contour, 3 soil fault, 2 soil alert, 1 idle, 0 scanning.
module ssfp_packer #(
	parameter int BASE_CYCLES = ssfp_pkg::BASE_CYCLES, // Cycles in one base period
	parameter bit EXTENDED = 1'b0 // Extended variant with eight paths
) (
	input wire logic pclk, // APB clock
	input wire logic presetn, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire ssfp_pkg::ssfp_snap_t snap, // Live scanner state
	output logic [63:0] std_frame, // Standard frame, byte 0 in bits 7:0
	output logic std_valid, // One-cycle pulse on refresh
	output logic [127:0] saf_frame, // Safety frame, byte 0 in bits 7:0
	output logic saf_valid, // One-cycle pulse on refresh
	output logic saf_conn, // Safety frame marked for safety connection
	output logic irq // Level interrupt
);
	logic [7:0] ctrl_r; // bit0 std enable, bit1 safety enable
	logic [7:0] rpi_mult_r;
	logic [31:0] base_cnt_r;
	logic [7:0] mult_cnt_r;
	logic tick_r;
	logic [1:0] irq_stat_r;
	logic [1:0] irq_en_r;
	logic [15:0] frame_cnt_r;
	logic [31:0] rdata_nxt;
	logic access;
	logic wr;
	logic clr_hit;
	logic [7:0] path_mask;
	logic [1:0] clr_mask;
	logic [1:0] set_mask;

	// Hides paths 5..8 on the basic variant so the frame never claims absent outputs
	function automatic logic [7:0] mask_paths(input logic [7:0] v, input logic [7:0] m);
		mask_paths = v & m;
	endfunction : mask_paths

	function automatic logic [7:0] status_byte(input ssfp_pkg::ssfp_status_t s);
		status_byte = {2'b00, s.tamper_detected, s.contour_reference_state,
			s.window_soil_fault, s.window_soil_alert, s.idle_state_flag,
			s.scanning_active_flag}; // [R7]
	endfunction : status_byte

	function automatic logic [7:0] fault_byte(input ssfp_pkg::ssfp_snap_t s);
		fault_byte = 8'h00;
		fault_byte[ssfp_pkg::FLT_UNIT] = s.unit_fault;
		fault_byte[ssfp_pkg::FLT_CONFIG] = s.config_fault;
	endfunction : fault_byte

	assign path_mask = EXTENDED ? 8'hff : 8'h0f; // [R6]
	// A write lands only on the edge that also sees ready, as the bus asks
	assign access = psel && penable && pready;
	assign wr = access && pwrite;
	assign clr_hit = wr && (paddr == ssfp_pkg::REG_IRQ_CLR);

	////////////////////////////////////////////////////////////////////////
	// Refresh timing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			base_cnt_r <= 32'h0;
			mult_cnt_r <= 8'h0;
			tick_r <= 1'b0;
		end else begin
			tick_r <= 1'b0;
			if (base_cnt_r == 32'(BASE_CYCLES - 1)) begin // [R2]
				base_cnt_r <= 32'h0;
				if (mult_cnt_r + 8'h1 >= rpi_mult_r) begin
					mult_cnt_r <= 8'h0;
					tick_r <= 1'b1;
				end else begin
					mult_cnt_r <= mult_cnt_r + 8'h1;
				end
			end else begin
				base_cnt_r <= base_cnt_r + 32'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Frame assembly; frames are outputs only, nothing flows back in
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			std_frame <= 64'h0;
			std_valid <= 1'b0;
		end else begin
			std_valid <= 1'b0;
			if (tick_r && ctrl_r[0]) begin // [R1]
				std_frame <= '0; // [R3]
				std_frame[ssfp_pkg::STD_STATUS*8 +: 8] <= status_byte(snap.status);
				std_frame[ssfp_pkg::STD_SAFE*8 +: 8] <=
					mask_paths(snap.safe_output_path_state, path_mask); // [R3]
				std_frame[ssfp_pkg::STD_PLAIN*8 +: 8] <=
					mask_paths(snap.plain_output_path_state, path_mask);
				std_frame[ssfp_pkg::STD_CASE*8 +: 8] <= snap.case_number;
				std_frame[ssfp_pkg::STD_RESTART*8 +: 8] <=
					mask_paths(snap.restart_needed_path, path_mask);
				std_frame[ssfp_pkg::STD_FAULT*8 +: 8] <= fault_byte(snap);
				std_valid <= 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			saf_frame <= 128'h0;
			saf_valid <= 1'b0;
			saf_conn <= 1'b0;
		end else begin
			saf_valid <= 1'b0;
			saf_conn <= ctrl_r[1]; // [R4]
			if (tick_r && ctrl_r[1]) begin
				saf_frame <= '0; // [R5]
				saf_frame[ssfp_pkg::SAF_STATUS*8 +: 8] <= status_byte(snap.status);
				saf_frame[ssfp_pkg::SAF_SAFE*8 +: 8] <=
					mask_paths(snap.safe_output_path_state, path_mask); // [R5]
				saf_frame[ssfp_pkg::SAF_PLAIN*8 +: 8] <=
					mask_paths(snap.plain_output_path_state, path_mask);
				saf_frame[ssfp_pkg::SAF_RESTART*8 +: 8] <=
					mask_paths(snap.restart_needed_path, path_mask);
				saf_frame[ssfp_pkg::SAF_CASE*8 +: 8] <= snap.case_number;
				saf_frame[ssfp_pkg::SAF_FAULT*8 +: 8] <= fault_byte(snap);
				saf_valid <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= ssfp_pkg::CTRL_RST;
			rpi_mult_r <= ssfp_pkg::RPI_MULT_RST;
			irq_en_r <= ssfp_pkg::IRQ_EN_RST;
		end else if (wr) begin
			case (paddr)
				ssfp_pkg::REG_CTRL: begin
					ctrl_r <= {6'h0, pwdata[1:0]};
					// Zero multiple is taken as one so a frame still goes out
					rpi_mult_r <= (pwdata[15:8] == 8'h0) ? 8'h1 : pwdata[15:8]; // [R2]
				end
				ssfp_pkg::REG_IRQ_EN: irq_en_r <= pwdata[1:0];
				default: ;
			endcase
		end
	end

	// Each sent frame raises its own sticky bit
	always_comb begin
		set_mask = 2'h0;
		set_mask[ssfp_pkg::IRQ_STD] = std_valid;
		set_mask[ssfp_pkg::IRQ_SAF] = saf_valid;
	end

	assign clr_mask = clr_hit ? pwdata[1:0] : 2'h0;

	// Set wins over a clear arriving in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_r <= 2'h0;
		end else begin
			irq_stat_r <= (irq_stat_r & ~clr_mask) | set_mask;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_cnt_r <= 16'h0;
		end else if (tick_r) begin
			frame_cnt_r <= frame_cnt_r + 16'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat_r & irq_en_r);
		end
	end

	always_comb begin
		rdata_nxt = 32'h0;
		case (paddr)
			ssfp_pkg::REG_CTRL: rdata_nxt = {16'h0, rpi_mult_r, ctrl_r};
			ssfp_pkg::REG_STATUS: rdata_nxt = {24'h0, status_byte(snap.status)};
			ssfp_pkg::REG_PATHS: rdata_nxt = {8'h0,
				mask_paths(snap.restart_needed_path, path_mask),
				mask_paths(snap.plain_output_path_state, path_mask),
				mask_paths(snap.safe_output_path_state, path_mask)};
			ssfp_pkg::REG_MISC: rdata_nxt = {16'h0, fault_byte(snap), snap.case_number};
			ssfp_pkg::REG_IRQ_STAT: rdata_nxt = {30'h0, irq_stat_r};
			ssfp_pkg::REG_IRQ_EN: rdata_nxt = {30'h0, irq_en_r};
			ssfp_pkg::REG_COUNT: rdata_nxt = {16'h0, frame_cnt_r};
			default: rdata_nxt = 32'h0;
		endcase
	end

	// No wait state: ready rises in the first access cycle, pulses once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			prdata <= (psel && !penable && !pwrite) ? rdata_nxt : prdata;
			pslverr <= psel && !penable && (paddr[1:0] != 2'b00 || paddr > ssfp_pkg::REG_COUNT);
		end
	end
endmodule : ssfp_packer

// [design/ssfp_pkg.sv]
package ssfp_pkg;
	// Clock and frame timing
	localparam int CLK_HZ = 20000000;
	localparam int BASE_PERIOD_MS = 5;
	localparam int BASE_CYCLES = CLK_HZ / 1000 * BASE_PERIOD_MS;
	localparam int STD_BYTES = 8;
	localparam int SAF_BYTES = 16;
	// Standard frame byte positions
	localparam int STD_STATUS = 0;
	localparam int STD_SAFE = 1;
	localparam int STD_PLAIN = 2;
	localparam int STD_CASE = 4;
	localparam int STD_RESTART = 5;
	localparam int STD_FAULT = 7;
	// Safety frame byte positions
	localparam int SAF_STATUS = 0;
	localparam int SAF_SAFE = 1;
	localparam int SAF_PLAIN = 4;
	localparam int SAF_RESTART = 7;
	localparam int SAF_CASE = 10;
	localparam int SAF_FAULT = 15;
	// Fault byte bits
	localparam int FLT_CONFIG = 0;
	localparam int FLT_UNIT = 1;
	// APB register byte addresses
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_PATHS = 8'h08;
	localparam logic [7:0] REG_MISC = 8'h0c;
	localparam logic [7:0] REG_IRQ_STAT = 8'h10;
	localparam logic [7:0] REG_IRQ_EN = 8'h14;
	localparam logic [7:0] REG_IRQ_CLR = 8'h18;
	localparam logic [7:0] REG_COUNT = 8'h1c;
	// Reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] RPI_MULT_RST = 8'h01;
	localparam logic [1:0] IRQ_EN_RST = 2'h0;
	// Interrupt bits
	localparam int IRQ_STD = 0;
	localparam int IRQ_SAF = 1;

	typedef struct packed {
		logic tamper_detected;
		logic contour_reference_state;
		logic window_soil_fault;
		logic window_soil_alert;
		logic idle_state_flag;
		logic scanning_active_flag;
	} ssfp_status_t;

	typedef struct packed {
		ssfp_status_t status;
		logic [7:0] safe_output_path_state;
		logic [7:0] plain_output_path_state;
		logic [7:0] restart_needed_path;
		logic [7:0] case_number;
		logic unit_fault;
		logic config_fault;
	} ssfp_snap_t;
endpackage : ssfp_pkg

// [bench/ssfp_chk.sv]
`timescale 1ns/1ns
module ssfp_chk #(
	parameter bit EXTENDED = 1'b0
) (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset
	input wire logic [63:0] std_frame, // Std frame
	input wire logic std_valid, // Std pulse
	input wire logic [127:0] saf_frame, // Safety frame
	input wire logic saf_valid, // Safety pulse
	input wire logic saf_conn, // Safety link
	input wire logic irq // Interrupt
);
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
a_std_pulse: assert property (std_valid |=> !std_valid [*8])
	else $error("std refresh too soon");
a_std_hold: assert property ($changed(std_frame) |-> std_valid)
	else $error("std frame moved between refreshes");
a_std_resv: assert property (std_valid |-> std_frame[31:24] == 0 &&
	std_frame[55:48] == 0 && std_frame[63:58] == 0) else $error("std reserved bits set");
a_saf_resv: assert property (saf_valid |-> saf_frame[31:16] == 0 &&
	saf_frame[55:40] == 0 && saf_frame[79:64] == 0 && saf_frame[127:122] == 0 &&
	saf_frame[119:88] == 0) else $error("safety reserved bits set");
a_status_top: assert property (std_valid |-> std_frame[7:6] == 0)
	else $error("status top bits set");
a_path_hi: assert property (std_valid && !EXTENDED |-> std_frame[15:12] == 0 &&
	std_frame[23:20] == 0 && std_frame[47:44] == 0) else $error("absent paths set");
a_saf_link: assert property (saf_valid |-> saf_conn)
	else $error("safety frame off link");
a_frames_agree: assert property (std_valid && saf_valid |->
	std_frame == {saf_frame[127:120], 8'h00, saf_frame[63:56], saf_frame[87:80], 8'h00,
	saf_frame[39:32], saf_frame[15:0]}) else $error("frames disagree");
c_both: cover property (std_valid && saf_valid);
c_irq: cover property ($rose(irq));
c_irq_off: cover property ($fell(irq));
endmodule : ssfp_chk

// [bench/ssfp_plc.sv]
`timescale 1ns/1ns
// Controller side only consumes frames; it never sends command data back
module ssfp_plc (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset
	input wire logic std_valid, // Std frame in
	input wire logic saf_valid, // Safety frame in
	input wire logic saf_conn, // Safety link open
	output int std_n, // Std frames taken
	output int saf_n // Safety frames taken
);
always_ff @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		std_n <= 0;
		saf_n <= 0;
	end else begin
		if (std_valid) std_n <= std_n + 1;
		if (saf_valid && saf_conn) saf_n <= saf_n + 1;
	end
end
endmodule : ssfp_plc

// [bench/tb_top.sv]
`timescale 1ns/1ns
module tb_top;
localparam int BASE = 20;
localparam bit EXT = 1'b0;
logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
logic [7:0] paddr = 8'h00;
logic [31:0] pwdata = 32'h0;
logic [31:0] prdata, rd;
logic pready, pslverr, std_valid, saf_valid, saf_conn, irq, er;
logic [63:0] std_frame;
logic [127:0] saf_frame;
logic [127:0] ef;
logic [31:0] c1;
ssfp_pkg::ssfp_snap_t snap = '0;
int bad_count = 0, total_checks = 0, std_n, saf_n, n0, s0;
time t0;
always #25 pclk = ~pclk;
ssfp_packer #(.BASE_CYCLES(BASE), .EXTENDED(EXT)) dut (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .snap(snap), .std_frame(std_frame),
	.std_valid(std_valid), .saf_frame(saf_frame), .saf_valid(saf_valid),
	.saf_conn(saf_conn), .irq(irq));
ssfp_plc plc (.pclk(pclk), .presetn(presetn), .std_valid(std_valid),
	.saf_valid(saf_valid), .saf_conn(saf_conn), .std_n(std_n), .saf_n(saf_n));
////////////////////////////////////////
task chk(input string n, input logic [127:0] e, input logic [127:0] s);
	total_checks++;
	if (s !== e) begin
		bad_count++;
		$display("ERROR %s expected %h seen %h", n, e, s);
	end
endtask : chk
function automatic logic [127:0] expf(input bit s);
	logic [7:0] m, st, sf, pl, rs, fb;
	m = EXT ? 8'hff : 8'h0f;
	st = {2'h0, snap.status};
	sf = snap.safe_output_path_state & m;
	pl = snap.plain_output_path_state & m;
	rs = snap.restart_needed_path & m;
	fb = {6'h00, snap.unit_fault, snap.config_fault};
	if (s) return {fb, 32'h0, snap.case_number, 16'h0, rs, 16'h0, pl, 16'h0, sf, st};
	return {64'h0, fb, 8'h00, rs, snap.case_number, 8'h00, pl, sf, st};
endfunction : expf
task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
	@(posedge pclk);
	psel <= 1'b1;
	penable <= 1'b0;
	pwrite <= w;
	paddr <= a;
	pwdata <= d;
	@(posedge pclk);
	penable <= 1'b1;
	do @(posedge pclk); while (pready !== 1'b1);
	rd = prdata;
	er = pslverr;
	psel <= 1'b0;
	penable <= 1'b0;
endtask : apb
task wv;
	int i;
	i = 0;
	do begin
		@(posedge pclk);
		i++;
	end while (std_valid !== 1'b1 && i < 500);
endtask : wv
task conclude;
	if (bad_count == 0 && total_checks > 0) $display("All checks passed");
	else $display("Checks failed");
	$finish;
endtask : conclude
// Snapshot only moves right after a refresh, so it is steady across every capture
always @(posedge pclk) begin
	if (std_valid === 1'b1) chk("std_frame", expf(1'b0), {64'h0, std_frame});
	if (saf_valid === 1'b1) chk("saf_frame", expf(1'b1), saf_frame);
	if (std_valid === 1'b1 || saf_valid === 1'b1) snap <= 40'({$urandom, $urandom});
end
initial begin
	#(50 * 5000);
	bad_count++;
	conclude;
end
initial begin
	n0 = $urandom(32'hc017cb1a);
	repeat (6) @(posedge pclk);
	presetn <= 1'b1;
	chk("idle frame", 128'h0, {64'h0, std_frame});
	apb(1'b0, 8'h20, 32'h0);
	chk("bad addr err", 1'h1, er);
	chk("bad addr data", 32'h0, rd);
	apb(1'b1, ssfp_pkg::REG_IRQ_EN, 32'h3);
	for (int m = 1; m <= 3; m++) begin
		apb(1'b1, ssfp_pkg::REG_CTRL, {16'h0, 8'(m), 8'h03});
		wv;
		wv;
		t0 = $time;
		n0 = std_n;
		s0 = saf_n;
		wv;
		chk("period", BASE * m, ($time - t0) / 50);
		chk("plc std", n0 + 1, std_n);
		chk("plc safety", s0 + 1, saf_n);
		chk("safety link", 1'h1, saf_conn);
	end
	chk("irq on", 1'h1, irq);
	apb(1'b0, ssfp_pkg::REG_IRQ_STAT, 32'h0);
	chk("irq stat", 32'h3, rd);
	apb(1'b1, ssfp_pkg::REG_IRQ_EN, 32'h0);
	repeat (2) @(posedge pclk);
	chk("irq masked", 1'h0, irq);
	apb(1'b1, ssfp_pkg::REG_CTRL, 32'h100);
	apb(1'b1, ssfp_pkg::REG_IRQ_CLR, 32'h3);
	apb(1'b0, ssfp_pkg::REG_IRQ_STAT, 32'h0);
	chk("irq cleared", 32'h0, rd);
	chk("safety link off", 1'h0, saf_conn);
	// Frames are off now, so the snapshot holds still for the register reads
	ef = expf(1'b0);
	apb(1'b0, ssfp_pkg::REG_CTRL, 32'h0);
	chk("ctrl read", 32'h100, rd);
	apb(1'b0, ssfp_pkg::REG_STATUS, 32'h0);
	chk("status read", {24'h0, ef[7:0]}, rd);
	apb(1'b0, ssfp_pkg::REG_PATHS, 32'h0);
	chk("paths read", {8'h0, ef[47:40], ef[23:8]}, rd);
	apb(1'b0, ssfp_pkg::REG_MISC, 32'h0);
	chk("misc read", {16'h0, ef[63:56], ef[39:32]}, rd);
	chk("good addr err", 1'h0, er);
	apb(1'b0, ssfp_pkg::REG_IRQ_CLR, 32'h0);
	chk("clear reads zero", 32'h0, rd);
	// Two count captures exactly five base periods apart
	apb(1'b0, ssfp_pkg::REG_COUNT, 32'h0);
	c1 = rd;
	repeat (BASE * 5 - 3) @(posedge pclk);
	apb(1'b0, ssfp_pkg::REG_COUNT, 32'h0);
	chk("tick count", 32'h5, rd - c1);
	conclude;
end
endmodule : tb_top
bind ssfp_packer ssfp_chk #(.EXTENDED(EXTENDED)) u_chk (.pclk(pclk), .presetn(presetn),
	.std_frame(std_frame), .std_valid(std_valid), .saf_frame(saf_frame),
	.saf_valid(saf_valid), .saf_conn(saf_conn), .irq(irq));
